// *** hdl/sbclk_pkg.sv ***
// shared constants for the southbridge clock unit
package sbclk_pkg;
  localparam int unsigned ISA_DIV          = 4;       // pci clock divided by four
  localparam int unsigned ISA_HALF         = ISA_DIV / 2;
  localparam int unsigned MCLK_HZ          = 25000000;
  localparam int unsigned SUS_CLK_HZ       = 32768;
  // mclk cycles per suspend clock half period; the unit takes its suspend clock from the rtc sample instead
  localparam int unsigned SUS_HALF_CYC     = MCLK_HZ / (2 * SUS_CLK_HZ);
  localparam logic        ISA_CLK_RST      = 1'b0;
  localparam logic        SUS_CLK_RST      = 1'b0;
  localparam int unsigned TMR_WATCH_CYC    = 64;      // mclk cycles without edge = stopped
  typedef enum logic [1:0] {SBCLK_RUN, SBCLK_POS, SBCLK_STD_OFF} sbclk_pwr_t;
endpackage

// *** hdl/sbclk_sync_if.sv ***
// synchronised clock samples passed between unit modules
`timescale 1ns/10ps
interface sbclk_sync_if;
  logic pci_rise;  // one-cycle pulse on pci clock rising edge
  logic rtc_level; // synchronised rtc oscillator level
  logic tmr_rise;  // one-cycle pulse on timer ref rising edge
  modport src (output pci_rise, rtc_level, tmr_rise);
  modport dst (input  pci_rise, rtc_level, tmr_rise);
endinterface

// *** hdl/sbclk_edge_sync.sv ***
// two-flop synchronisers for external clocks, rising edge detectors for the pci and timer clocks only
`timescale 1ns/10ps
module sbclk_edge_sync (
  input  wire logic mclk_in,     // system clock
  input  wire logic sys_rst_in,  // sync reset, active high
  input  wire logic pci_clk_in,  // raw pci clock
  input  wire logic rtc_clk_in,  // raw rtc oscillator
  input  wire logic tmr_clk_in,  // raw timer reference
  sbclk_sync_if.src sync         // synchronised samples
);
  logic [2:0] pci_s_r;
  logic [2:0] rtc_s_r;
  logic [2:0] tmr_s_r;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rtc_s_r <= 3'h0;
      tmr_s_r <= 3'h0;
    end else begin
      rtc_s_r <= {rtc_s_r[1:0], rtc_clk_in};
      tmr_s_r <= {tmr_s_r[1:0], tmr_clk_in};
    end
  end

  // pci chain has no reset: the isa clock must keep running through reset
  always_ff @(posedge mclk_in) begin
    pci_s_r <= {pci_s_r[1:0], pci_clk_in};
  end

  // only stages 1 and 2 feed logic; stage 0 is the metastability catcher
  assign sync.pci_rise  = pci_s_r[1] & ~pci_s_r[2]; // [RULE2]
  assign sync.rtc_level = rtc_s_r[1];
  assign sync.tmr_rise  = tmr_s_r[1] & ~tmr_s_r[2];
endmodule

// *** hdl/sbclk_unit.sv ***
// southbridge clock unit: isa clock divider, suspend clock, timer clock watch
`timescale 1ns/10ps
// Behaviour
// [RULE1] outside source supplies free-running pci clock at 30 or 33 MHz
// [RULE2] pci signals sampled on pci clock rising edge
// [RULE3] system keeps pci clock toggling at all times
// [RULE4] isa clock is pci clock divided by four
// [RULE5] isa clock therefore runs at 7.5 or 8.33 MHz
// [RULE6] isa clock low phase may stretch so address latch falls on rising edge
// [RULE7] isa clock runs in and after reset, held low in power-on-suspend
// [RULE8] 32.768 kHz suspend clock goes out to the host bridge
// [RULE9] suspend clock stops in suspend-to-disk and soft-off
// [RULE10] timer reference clock may stop in suspend without harm
// [RULE11] suspend clock taken from the always-running rtc oscillator
module sbclk_unit
  import sbclk_pkg::*;
(
  input  wire logic mclk_in,                   // 25 MHz system clock
  input  wire logic sys_rst_in,                // sync reset, active high
  input  wire logic pci_bus_clock_in,          // free-running pci clock pin
  input  wire logic timer_ref_clock_in,        // timer reference clock pin
  input  wire logic rtc_crystal_in,            // rtc oscillator level
  input  wire logic isa_stretch_req_in,        // hold isa clock low (latch align)
  input  wire logic pwr_on_suspend_in,         // system in power-on-suspend
  input  wire logic pwr_std_off_in,            // suspend-to-disk or soft-off
  output logic      isa_bus_clock_out,         // isa reference clock
  output logic      suspend_refresh_clock_out, // 32.768 kHz to host bridge
  output logic      rtc_crystal_out,           // rtc oscillator drive
  output logic      timer_clk_stopped_out,     // timer reference seen stopped
  output logic      timer_tick_out             // one pulse per timer ref rising edge
);
  sbclk_sync_if sync ();
  sbclk_edge_sync u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .pci_clk_in (pci_bus_clock_in),
    .rtc_clk_in (rtc_crystal_in),
    .tmr_clk_in (timer_ref_clock_in),
    .sync       (sync)
  );

  sbclk_pwr_t pwr_r;
  logic [1:0] isa_cnt_r;
  logic       isa_clk_r;
  logic       sus_clk_r;
  logic       rtc_inv_r;
  logic [6:0] tmr_idle_r;
  logic       tmr_stop_r;
  logic       tick_r;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pwr_r <= SBCLK_RUN;
    end else if (pwr_std_off_in) begin
      pwr_r <= SBCLK_STD_OFF;
    end else if (pwr_on_suspend_in) begin
      pwr_r <= SBCLK_POS;
    end else begin
      pwr_r <= SBCLK_RUN;
    end
  end

  // divider counts pci rising edges; it keeps running through reset so the
  // isa clock never stops while reset is asserted
  always_ff @(posedge mclk_in) begin
    if (pwr_r == SBCLK_POS) begin
      isa_cnt_r <= 2'h0;
      isa_clk_r <= ISA_CLK_RST; // [RULE7]
    end else if (sync.pci_rise) begin
      if (isa_cnt_r == 2'(ISA_HALF - 1)) begin
        if (!isa_clk_r && isa_stretch_req_in) begin
          isa_clk_r <= 1'b0; // [RULE6]
        end else begin
          isa_cnt_r <= 2'h0;
          isa_clk_r <= ~isa_clk_r; // [RULE4] [RULE5]
        end
      end else if (isa_cnt_r < 2'(ISA_HALF - 1)) begin
        isa_cnt_r <= isa_cnt_r + 2'h1;
      end else begin
        // unknown or unused count after power-up: realign rather than lock up
        isa_cnt_r <= 2'h0;
        isa_clk_r <= ISA_CLK_RST;
      end
    end
  end

  // suspend clock follows the rtc oscillator, which never stops
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || pwr_r == SBCLK_STD_OFF) begin
      sus_clk_r <= SUS_CLK_RST; // [RULE9]
    end else begin
      sus_clk_r <= sync.rtc_level; // [RULE8] [RULE11]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rtc_inv_r <= 1'b1;
    end else begin
      rtc_inv_r <= ~sync.rtc_level;
    end
  end

  // timer reference watch: a stopped clock only raises a flag, never hangs
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tmr_idle_r <= 7'h0;
      tmr_stop_r <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      tick_r <= sync.tmr_rise;
      if (sync.tmr_rise) begin
        tmr_idle_r <= 7'h0;
        tmr_stop_r <= 1'b0;
      end else if (tmr_idle_r == 7'(TMR_WATCH_CYC)) begin
        tmr_stop_r <= 1'b1; // [RULE10]
      end else begin
        tmr_idle_r <= tmr_idle_r + 7'h1;
      end
    end
  end

  assign isa_bus_clock_out         = isa_clk_r;
  assign suspend_refresh_clock_out = sus_clk_r;
  assign rtc_crystal_out           = rtc_inv_r;
  assign timer_clk_stopped_out     = tmr_stop_r;
  assign timer_tick_out            = tick_r;
endmodule

// *** verif/sbclk_unit_sva.sv ***
// port assertions for the clock unit
`timescale 1ns/10ps
module sbclk_unit_sva (
  input wire logic mclk_in,                   // clock
  input wire logic sys_rst_in,                // reset
  input wire logic isa_stretch_req_in,        // stretch
  input wire logic pwr_on_suspend_in,         // pos
  input wire logic pwr_std_off_in,            // std/off
  input wire logic isa_bus_clock_out,         // isa
  input wire logic suspend_refresh_clock_out, // sus
  input wire logic rtc_crystal_out,           // rtc drive
  input wire logic timer_clk_stopped_out,     // stopped
  input wire logic timer_tick_out             // tick
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // pci at four mclk: each isa phase lasts about eight
  property p_isa_high;
    disable iff (sys_rst_in || pwr_on_suspend_in)
    $rose(isa_bus_clock_out) |-> isa_bus_clock_out [*6] ##[1:4] !isa_bus_clock_out;
  endproperty
  a_isa_high: assert property (p_isa_high) else $error("isa high phase length");
  property p_isa_low;
    disable iff (sys_rst_in || pwr_on_suspend_in)
    $fell(isa_bus_clock_out) |-> ##[6:10] (isa_bus_clock_out || isa_stretch_req_in);
  endproperty
  a_isa_low: assert property (p_isa_low) else $error("isa low phase length");
  property p_stretch;
    isa_stretch_req_in [*2] |-> !$rose(isa_bus_clock_out);
  endproperty
  a_stretch: assert property (p_stretch) else $error("isa rose while stretched");
  property p_pos;
    (pwr_on_suspend_in && !pwr_std_off_in) [*2] |=> !isa_bus_clock_out;
  endproperty
  a_pos: assert property (p_pos) else $error("isa not low in pos");
  property p_std;
    pwr_std_off_in [*2] |=> !suspend_refresh_clock_out;
  endproperty
  a_std: assert property (p_std) else $error("suspend clock runs in off");
  property p_rst;
    disable iff (1'b0)
    sys_rst_in |=> rtc_crystal_out && !timer_tick_out && !suspend_refresh_clock_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset output values");
  property p_tick;
    timer_tick_out |=> !timer_tick_out;
  endproperty
  a_tick: assert property (p_tick) else $error("tick wider than one cycle");
  property p_stop;
    timer_tick_out |=> ##1 !timer_clk_stopped_out [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("stopped while ticking");
endmodule
bind sbclk_unit sbclk_unit_sva u_sva (.*);

// *** verif/sbclk_far_model.sv ***
// far side clock sources: pci, rtc oscillator, timer reference
`timescale 1ns/10ps
module sbclk_far_model (
  input  wire logic tmr_run_in,  // timer reference may toggle
  output logic      pci_clk_out, // pci clock, slowed so mclk can sample it
  output logic      rtc_clk_out, // rtc oscillator, period shortened
  output logic      tmr_clk_out  // timer reference, stoppable
);
  initial {pci_clk_out, rtc_clk_out, tmr_clk_out} = 3'h0;
  always #80 pci_clk_out = ~pci_clk_out;
  always #1000 rtc_clk_out = ~rtc_clk_out;
  always #200 if (tmr_run_in) tmr_clk_out = ~tmr_clk_out;
endmodule

// *** verif/sbclk_unit_bench.sv ***
// bench for the southbridge clock unit
`timescale 1ns/10ps
module sbclk_unit_bench;
  import sbclk_pkg::*;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, pos = 1'b0, std = 1'b0, str = 1'b0, trun = 1'b1;
  logic pci, rtc, tmr, isa, sus, rco, stp, tick;
  int   fails = 0, n_compared = 0, ri, rs, i;
  logic [3:0] rows [4] = '{4'h3, 4'h9, 4'h6, 4'he}; // pos, std, isa runs, sus runs; std wins
  always #20 mclk_in = ~mclk_in;
  sbclk_far_model far (.tmr_run_in(trun), .pci_clk_out(pci), .rtc_clk_out(rtc), .tmr_clk_out(tmr));
  sbclk_unit uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .pci_bus_clock_in(pci),
    .timer_ref_clock_in(tmr), .rtc_crystal_in(rtc), .isa_stretch_req_in(str),
    .pwr_on_suspend_in(pos), .pwr_std_off_in(std), .isa_bus_clock_out(isa),
    .suspend_refresh_clock_out(sus), .rtc_crystal_out(rco), .timer_clk_stopped_out(stp),
    .timer_tick_out(tick));
  task chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin fails++; $display("Error %0t: output mismatch", $time); end
  endtask
  // counts rising edges of both clocks over n cycles
  task run(input int n); logic pi, ps;
    ri = 0; rs = 0;
    repeat (n) begin
      pi = isa; ps = sus; @(negedge mclk_in);
      ri += int'(isa && !pi); rs += int'(sus && !ps);
    end
  endtask
  task conclude;
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    for (i = 0; i < 4; i++) begin
      {pos, std} = rows[i][3:2];
      run(8); run(128);
      chk(((ri >= 128 / (ISA_DIV * 4) - 1) && (ri <= 9)) === rows[i][1]);
      chk((rs > 0) === rows[i][0]);
    end
    {pos, std} = 2'h0; str = 1'b1; run(64); chk(ri === 0);
    str = 1'b0; run(64); chk(ri >= 3);
    sys_rst_in = 1'b1; run(40); chk(ri >= 2 && rco === 1'b1 && tick === 1'b0);
    sys_rst_in = 1'b0; trun = 1'b0; run(TMR_WATCH_CYC + 16); chk(stp === 1'b1);
    trun = 1'b1; run(30); chk(stp === 1'b0);
    conclude;
  end
endmodule
